// file: core/fp_exc_defs.vh
// constants for the single-precision exception responder
// assumes: included by core/ design files, no other context needed
`ifndef FP_EXC_DEFS_VH
`define FP_EXC_DEFS_VH

// ********************************
// status and mask bit positions
// ********************************
`define FLG_INV     0
`define FLG_DEN     1
`define FLG_DIVZ    2
`define FLG_OVF     3
`define FLG_UNF     4
`define FLG_INX     5
`define FLG_W       6
`define FLG_RESET   6'h00

// ********************************
// rounding control encodings
// ********************************
`define RND_NEAR    2'h0
`define RND_DOWN    2'h1
`define RND_UP      2'h2
`define RND_ZERO    2'h3

// ********************************
// single-precision format figures
// ********************************
`define SP_MANT_W   5'h18
`define EXP_MIN     13'sh1f82
`define EXP_MAX     13'sh007f
`define EXP_BIAS    13'sh007f
`define EXP_SCALE   13'sh00c0
`define SP_MAX_EXP  8'hfe
`define SP_INF_EXP  8'hff

// ********************************
// trap vector and timing
// ********************************
`define TRAP_VEC    8'h13
`define LAT_CYCLES  1

`endif

// file: core/sig_rounder.v
// single rounding of an exact significand to a chosen number of bits
// assumes: sig_i normalised with its leading one in the top bit
`timescale 1ns/1ps
`include "fp_exc_defs.vh"

module sig_rounder #(
    parameter SIG_W = 56
) (
    input  wire [SIG_W-1:0] sig_i,
    input  wire             sticky_i,
    input  wire             sign_i,
    input  wire [1:0]       mode_i,
    input  wire [4:0]       keep_i,
    output reg  [24:0]      mant_o,
    output reg              inexact_o
);
    localparam W = SIG_W + 8;

    reg [W-1:0] wide;
    reg [W-1:0] kept;
    reg [W-1:0] below;
    reg         rbit;
    reg         sbit;
    reg         inc;

    // rounding straight from the exact value avoids a second rounding
    always @* begin
        wide      = {sig_i, 8'h00};
        kept      = wide >> (W - keep_i);
        rbit      = wide[W - 1 - keep_i];
        below     = wide << (keep_i + 5'h01);
        sbit      = (|below) | sticky_i;
        inexact_o = rbit | sbit;
        case (mode_i)
            `RND_NEAR: inc = rbit & (sbit | kept[0]);
            `RND_DOWN: inc = sign_i & inexact_o;
            `RND_UP:   inc = ~sign_i & inexact_o;
            default:   inc = 1'b0;
        endcase
        mant_o = {1'b0, kept[23:0]} + {24'h000000, inc};
    end

endmodule

// file: core/fp_exc_responder.v
// exception response for one single-precision lane: operand
// denormal squashing, rounding, tiny/huge handling, flags and trap
// assumes: the arithmetic core supplies an exact result (sign,
// unbiased exponent, normalised significand, sticky) and its fault
// flags in the same cycle as res_valid_i
`timescale 1ns/1ps
`include "fp_exc_defs.vh"

module fp_exc_responder #(
    parameter SIG_W = 56
) (
    input  wire              clk_sys_i,
    input  wire              rst_n_i,
    input  wire [31:0]       opd_a_i,
    input  wire [31:0]       opd_b_i,
    input  wire              daz_i,
    input  wire              ftz_i,
    input  wire [1:0]        rnd_mode_i,
    input  wire [5:0]        exc_mask_i,
    input  wire              res_valid_i,
    input  wire              res_sign_i,
    input  wire [11:0]       res_exp_i,
    input  wire [SIG_W-1:0]  res_sig_i,
    input  wire              res_sticky_i,
    input  wire              res_special_i,
    input  wire [31:0]       res_special_val_i,
    input  wire              flt_invalid_i,
    input  wire              flt_denormal_i,
    input  wire              flt_divzero_i,
    input  wire              status_wr_i,
    input  wire [5:0]        status_wdata_i,
    output wire [31:0]       opd_a_o,
    output wire [31:0]       opd_b_o,
    output wire [31:0]       result_o,
    output wire              result_valid_o,
    output wire              trap_o,
    output wire [7:0]        trap_vector_o,
    output wire [5:0]        trap_cause_o,
    output wire [5:0]        simd_fp_control_status_o,
    output wire              underflow_flag_o,
    output wire              inexact_flag_o
);

    // ********************************
    // functions
    // ********************************
    // squash denormal operand
    function [31:0] squash_denorm;
        input [31:0] x;
        input        en;
        begin
            if (en && (x[30:23] == 8'h00))
                squash_denorm = {x[31], 31'h00000000};
            else
                squash_denorm = x;
        end
    endfunction

    function [31:0] pack_sp;
        input        s;
        input [12:0] e_biased;
        input [22:0] frac;
        begin
            pack_sp = {s, e_biased[7:0], frac};
        end
    endfunction

    // ********************************
    // registers
    // ********************************
    reg [31:0] opd_a_q;
    reg [31:0] opd_b_q;
    reg [31:0] result_q;
    reg        valid_q;
    reg        trap_q;
    reg [7:0]  vec_q;
    reg [5:0]  cause_q;
    reg [5:0]  status_q;

    reg [31:0] result_d;
    reg        trap_d;
    reg [5:0]  cause_d;
    reg [5:0]  flags_d;

    // ********************************
    // rounding, unbounded and denormal
    // ********************************
    wire        [24:0] mant_unb;
    wire               inx_unb;
    wire        [24:0] mant_dn;
    wire               inx_dn;
    wire signed [12:0] exp_exact;
    wire signed [12:0] exp_unb;
    wire signed [12:0] exp_bias;
    wire signed [12:0] dn_shift;
    wire        [4:0]  keep_dn;
    wire               far_dn;
    wire               tiny;
    wire               huge;
    wire        [2:0]  faults;
    wire        [2:0]  fault_trap;
    wire               max_not_inf;

    assign exp_exact = {res_exp_i[11], res_exp_i};
    // a carry out of rounding bumps the exponent
    assign exp_unb   = exp_exact + {12'h000, mant_unb[24]};
    assign exp_bias  = exp_unb + `EXP_BIAS;

    assign tiny = exp_unb < `EXP_MIN;
    assign huge = exp_unb > `EXP_MAX;

    // shift to bring exponent up to -126
    assign dn_shift = `EXP_MIN - exp_exact;
    assign keep_dn  = (dn_shift >= 13'sh0018) ? 5'h00 :
                      (dn_shift <= 13'sh0000) ? `SP_MANT_W :
                      (`SP_MANT_W - dn_shift[4:0]);
    assign far_dn   = dn_shift > 13'sh0018;

    // inexact detected in the unbounded rounding
    sig_rounder #(
        .SIG_W     (SIG_W)
    ) u_round_unb (
        .sig_i     (res_sig_i),
        .sticky_i  (res_sticky_i),
        .sign_i    (res_sign_i),
        .mode_i    (rnd_mode_i),
        .keep_i    (`SP_MANT_W),
        .mant_o    (mant_unb),
        .inexact_o (inx_unb)
    );

    // denormal rounded once from the exact value
    sig_rounder #(
        .SIG_W     (SIG_W)
    ) u_round_dn (
        .sig_i     (far_dn ? {SIG_W{1'b0}} : res_sig_i),
        .sticky_i  (far_dn | res_sticky_i),
        .sign_i    (res_sign_i),
        .mode_i    (rnd_mode_i),
        .keep_i    (keep_dn),
        .mant_o    (mant_dn),
        .inexact_o (inx_dn)
    );

    // mask bits share the flag positions
    assign faults[`FLG_INV]  = flt_invalid_i;
    assign faults[`FLG_DEN]  = flt_denormal_i & ~flt_divzero_i;
    assign faults[`FLG_DIVZ] = flt_divzero_i;
    assign fault_trap        = faults & ~exc_mask_i[2:0];

    // masked overflow rounds away from infinity in these cases
    assign max_not_inf = (rnd_mode_i == `RND_ZERO) ||
                         ((rnd_mode_i == `RND_DOWN) && !res_sign_i) ||
                         ((rnd_mode_i == `RND_UP) && res_sign_i);

    // ********************************
    // response selection
    // ********************************
    always @* begin
        result_d = pack_sp(res_sign_i, exp_bias, mant_unb[22:0]);
        trap_d   = 1'b0;
        cause_d  = 6'h00;
        flags_d  = {3'h0, faults};
        // fault class first, in priority order
        if (|fault_trap) begin
            trap_d   = 1'b1;
            result_d = 32'h00000000;
            if (fault_trap[`FLG_INV])
                cause_d[`FLG_INV] = 1'b1;
            else if (fault_trap[`FLG_DEN])
                cause_d[`FLG_DEN] = 1'b1;
            else
                cause_d[`FLG_DIVZ] = 1'b1;
            flags_d = cause_d;
        end else if (res_special_i) begin
            result_d = res_special_val_i;
        end else if (tiny) begin
            if (!exc_mask_i[`FLG_UNF]) begin
                result_d = pack_sp(res_sign_i, exp_bias + `EXP_SCALE,
                                   mant_unb[22:0]);
                flags_d[`FLG_UNF] = 1'b1;
                flags_d[`FLG_INX] = inx_unb;
                trap_d            = 1'b1;
                cause_d[`FLG_UNF] = 1'b1;
            end else begin
                // flush a tiny result to zero
                if (ftz_i) begin
                    result_d          = {res_sign_i, 31'h00000000};
                    flags_d[`FLG_UNF] = 1'b1;
                    flags_d[`FLG_INX] = 1'b1;
                end else begin
                    result_d = {res_sign_i, 7'h00, mant_dn[23:0]};
                    flags_d[`FLG_UNF] = inx_dn;
                    flags_d[`FLG_INX] = inx_dn;
                end
                // inexact trap carries the masked result
                if (flags_d[`FLG_INX] && !exc_mask_i[`FLG_INX]) begin
                    trap_d            = 1'b1;
                    cause_d[`FLG_INX] = 1'b1;
                end
            end
        end else if (huge) begin
            if (!exc_mask_i[`FLG_OVF]) begin
                result_d = pack_sp(res_sign_i, exp_bias - `EXP_SCALE,
                                   mant_unb[22:0]);
                flags_d[`FLG_OVF] = 1'b1;
                flags_d[`FLG_INX] = inx_unb;
                trap_d            = 1'b1;
                cause_d[`FLG_OVF] = 1'b1;
            end else begin
                if (max_not_inf)
                    result_d = {res_sign_i, `SP_MAX_EXP, 23'h7fffff};
                else
                    result_d = {res_sign_i, `SP_INF_EXP, 23'h000000};
                flags_d[`FLG_OVF] = 1'b1;
                flags_d[`FLG_INX] = 1'b1;
                if (!exc_mask_i[`FLG_INX]) begin
                    trap_d            = 1'b1;
                    cause_d[`FLG_INX] = 1'b1;
                end
            end
        end else if (inx_unb) begin
            flags_d[`FLG_INX] = 1'b1;
            if (!exc_mask_i[`FLG_INX]) begin
                trap_d            = 1'b1;
                cause_d[`FLG_INX] = 1'b1;
            end
        end
    end

    // ********************************
    // output and status registers
    // ********************************
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            opd_a_q  <= 32'h00000000;
            opd_b_q  <= 32'h00000000;
            result_q <= 32'h00000000;
            valid_q  <= 1'b0;
            trap_q   <= 1'b0;
            vec_q    <= 8'h00;
            cause_q  <= 6'h00;
            status_q <= `FLG_RESET;
        end else begin
            opd_a_q <= squash_denorm(opd_a_i, daz_i);
            opd_b_q <= squash_denorm(opd_b_i, daz_i);
            valid_q <= res_valid_i;
            trap_q  <= res_valid_i & trap_d;
            if (res_valid_i) begin
                result_q <= result_d;
                cause_q  <= cause_d;
                vec_q    <= trap_d ? `TRAP_VEC : 8'h00;
            end
            // sticky flags, a new event beats a software clear
            if (status_wr_i && res_valid_i)
                status_q <= status_wdata_i | flags_d;
            else if (status_wr_i)
                status_q <= status_wdata_i;
            else if (res_valid_i)
                status_q <= status_q | flags_d;
        end
    end

    assign opd_a_o                  = opd_a_q;
    assign opd_b_o                  = opd_b_q;
    assign result_o                 = result_q;
    assign result_valid_o           = valid_q;
    assign trap_o                   = trap_q;
    assign trap_vector_o            = vec_q;
    assign trap_cause_o             = cause_q;
    assign simd_fp_control_status_o = status_q;
    assign underflow_flag_o         = status_q[`FLG_UNF];
    assign inexact_flag_o           = status_q[`FLG_INX];

endmodule

// file: dv/fp_exc_responder_properties.sv
// port assertions for the single-precision exception responder
// assumes: bound onto fp_exc_responder, one clock, sync reset
`timescale 1ns/1ps

module fp_exc_responder_properties (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [31:0] opd_a_i,
    input wire logic        daz_i,
    input wire logic [5:0]  exc_mask_i,
    input wire logic        res_valid_i,
    input wire logic        status_wr_i,
    input wire logic [31:0] opd_a_o,
    input wire logic        result_valid_o,
    input wire logic        trap_o,
    input wire logic [7:0]  trap_vector_o,
    input wire logic [5:0]  trap_cause_o,
    input wire logic [5:0]  simd_fp_control_status_o,
    input wire logic        underflow_flag_o,
    input wire logic        inexact_flag_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    // ************
    // properties
    // ************
    AST_VALID_LAT: assert property (res_valid_i |=> result_valid_o)
        else $error("result valid missing");
    AST_TRAP_VEC: assert property (trap_o |-> trap_vector_o == 8'h13)
        else $error("trap vector wrong");
    AST_CAUSE_ONE: assert property (trap_o |-> $onehot(trap_cause_o))
        else $error("trap cause not one-hot");
    AST_CAUSE_UNM: assert property (
        trap_o |-> (trap_cause_o & $past(exc_mask_i)) == 6'h00)
        else $error("trap on masked cause");
    AST_CAUSE_FLAG: assert property (
        trap_o |-> (simd_fp_control_status_o & trap_cause_o) == trap_cause_o)
        else $error("cause flag not set");
    // flags only fall through a software write
    AST_STICKY: assert property (
        !status_wr_i |=> ($past(simd_fp_control_status_o)
            & ~simd_fp_control_status_o) == 6'h00)
        else $error("status flag cleared by itself");
    AST_FLAG_BITS: assert property (
        {inexact_flag_o, underflow_flag_o} == simd_fp_control_status_o[5:4])
        else $error("flag outputs disagree with status");
    AST_DAZ: assert property (
        daz_i && opd_a_i[30:23] == 8'h00
        |=> opd_a_o == ($past(opd_a_i) & 32'h80000000))
        else $error("denormal operand not squashed");
endmodule

bind fp_exc_responder fp_exc_responder_properties u_props (
    .clk_sys_i, .rst_n_i, .opd_a_i, .daz_i, .exc_mask_i, .res_valid_i,
    .status_wr_i, .opd_a_o, .result_valid_o, .trap_o, .trap_vector_o,
    .trap_cause_o, .simd_fp_control_status_o, .underflow_flag_o,
    .inexact_flag_o
);

// file: dv/simd_sp_float_exception_responder_tb_top.sv
// self-checking bench for the exception responder
// assumes: core/ on the include path, checker bound separately
`timescale 1ns/1ps
`include "fp_exc_defs.vh"

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", n, e, g); end end

module simd_sp_float_exception_responder_tb_top;
    localparam logic [55:0] ONE = 56'h80000000000000;
    localparam logic [55:0] ONE5 = 56'hc0000000000000;
    logic        clk_sys_i, rst_n_i, daz_i, ftz_i, res_valid_i, res_sign_i;
    logic        res_sticky_i, res_special_i, flt_invalid_i, flt_denormal_i;
    logic        flt_divzero_i, status_wr_i, result_valid_o, trap_o, clr;
    logic        underflow_flag_o, inexact_flag_o;
    logic [1:0]  rnd_mode_i;
    logic [5:0]  exc_mask_i, status_wdata_i, trap_cause_o, st;
    logic [5:0]  simd_fp_control_status_o;
    logic [7:0]  trap_vector_o;
    logic [11:0] res_exp_i, e;
    logic [55:0] res_sig_i, sg;
    logic [31:0] opd_a_i, opd_b_i, res_special_val_i, opd_a_o, opd_b_o;
    logic [31:0] result_o, v, w, seed = 32'h0000005f;
    logic [32:0] x;
    int          err_count = 0;
    int          tests_run = 0;

    fp_exc_responder #(.SIG_W(56)) dut (
        .clk_sys_i, .rst_n_i, .opd_a_i, .opd_b_i, .daz_i, .ftz_i,
        .rnd_mode_i, .exc_mask_i, .res_valid_i, .res_sign_i, .res_exp_i,
        .res_sig_i, .res_sticky_i, .res_special_i, .res_special_val_i,
        .flt_invalid_i, .flt_denormal_i, .flt_divzero_i, .status_wr_i,
        .status_wdata_i, .opd_a_o, .opd_b_o, .result_o, .result_valid_o,
        .trap_o, .trap_vector_o, .trap_cause_o, .simd_fp_control_status_o,
        .underflow_flag_o, .inexact_flag_o
    );

    // ************
    // helpers
    // ************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] sq(input logic [31:0] f, input logic en);
        return (en && f[30:23] == 8'h00) ? {f[31], 31'h0} : f;
    endfunction

    // in-range results only: carry into the exponent falls out of the add
    function automatic logic [32:0] rnd(input logic s, input logic [11:0] ex,
            input logic [55:0] sig, input logic stk, input logic [1:0] md);
        logic g;
        logic r;
        logic inc;
        g = sig[31];
        r = (|sig[30:0]) | stk;
        case (md)
            2'h0: inc = g & (r | sig[32]);
            2'h1: inc = s & (g | r);
            2'h2: inc = !s & (g | r);
            default: inc = 1'b0;
        endcase
        return {g | r, {s, ex[7:0] + 8'h7f, sig[54:32]} + {31'h0, inc}};
    endfunction

    task automatic wr(input logic [5:0] d);
        status_wr_i = 1'b1;
        status_wdata_i = d;
        @(negedge clk_sys_i);
        st = d;
        `CHK("status", st, simd_fp_control_status_o)
    endtask

    task automatic op(input logic [5:0] m, input logic s,
            input logic [11:0] ex, input logic [55:0] sig,
            input logic [31:0] er, input logic [5:0] ef, ec);
        logic [31:0] a;
        logic [31:0] b;
        a = xs();
        // odd draws become denormals so the squash path is hit often
        if (a[0]) a = a & 32'h807fffff;
        opd_a_i = a;
        opd_b_i = a ^ 32'h80000000;
        daz_i = a[1];
        exc_mask_i = m;
        res_sign_i = s;
        res_exp_i = ex;
        res_sig_i = sig;
        status_wr_i = clr;
        status_wdata_i = 6'h00;
        res_valid_i = 1'b1;
        @(negedge clk_sys_i);
        st = (clr ? 6'h00 : st) | ef;
        b = sq(a, daz_i);
        `CHK("result", er, result_o)
        `CHK("status", st, simd_fp_control_status_o)
        `CHK("trap", ec != 6'h00, trap_o)
        `CHK("cause", ec, trap_cause_o)
        `CHK("vector", ec != 6'h00 ? `TRAP_VEC : 8'h00, trap_vector_o)
        `CHK("operand", b, opd_a_o)
        `CHK("operand_b", sq(a ^ 32'h80000000, daz_i), opd_b_o)
        `CHK("flags", st[5:4], {inexact_flag_o, underflow_flag_o})
        `CHK("valid", 1'b1, result_valid_o)
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ************
    // stimulus
    // ************
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        {rst_n_i, daz_i, ftz_i, res_valid_i, res_sign_i, clr} = 6'h00;
        {res_sticky_i, res_special_i, flt_invalid_i} = 3'h0;
        {flt_denormal_i, flt_divzero_i, status_wr_i} = 3'h0;
        {rnd_mode_i, exc_mask_i, status_wdata_i, st} = 20'h00000;
        {opd_a_i, opd_b_i, res_special_val_i} = 96'h0;
        {res_exp_i, res_sig_i} = 68'h0;
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        wr(6'h3f);
        wr(6'h00);
        // clearing beside each result also checks that a set wins
        clr = 1'b1;
        op(6'h3f, 1'b0, 12'hf7e, ONE, 32'h00080000, 6'h00, 6'h00);
        op(6'h3f, 1'b1, 12'hf6b, ONE5, 32'h80000002, 6'h30, 6'h00);
        op(6'h3f, 1'b0, 12'hf81, 56'h800002ffffffff, 32'h00400001, 6'h30,
            6'h00);
        op(6'h3f, 1'b0, 12'hf81, 56'hffffffffffffff, 32'h00800000, 6'h20,
            6'h00);
        op(6'h3f, 1'b0, 12'hf82, ONE, 32'h00800000, 6'h00, 6'h00);
        op(6'h1f, 1'b0, 12'hf6b, ONE5, 32'h00000002, 6'h30, 6'h20);
        op(6'h2f, 1'b1, 12'hf7e, ONE, 32'hde800000, 6'h10, 6'h10);
        ftz_i = 1'b1;
        op(6'h3f, 1'b1, 12'hf7e, ONE, 32'h80000000, 6'h30, 6'h00);
        ftz_i = 1'b0;
        op(6'h3f, 1'b0, 12'h080, ONE, 32'h7f800000, 6'h28, 6'h00);
        op(6'h37, 1'b0, 12'h080, ONE, 32'h1f800000, 6'h08, 6'h08);
        rnd_mode_i = `RND_ZERO;
        op(6'h3f, 1'b0, 12'h080, ONE, 32'h7f7fffff, 6'h28, 6'h00);
        rnd_mode_i = `RND_UP;
        op(6'h3f, 1'b0, 12'hf68, ONE5, 32'h00000001, 6'h30, 6'h00);
        rnd_mode_i = `RND_NEAR;
        op(6'h3f, 1'b0, 12'hf68, ONE5, 32'h00000000, 6'h30, 6'h00);
        {flt_invalid_i, flt_denormal_i} = 2'h3;
        op(6'h00, 1'b0, 12'h000, ONE, 32'h00000000, 6'h01, 6'h01);
        {flt_invalid_i, flt_divzero_i} = 2'h1;
        op(6'h3b, 1'b0, 12'h000, ONE, 32'h00000000, 6'h04, 6'h04);
        op(6'h3f, 1'b0, 12'h000, ONE, 32'h3f800000, 6'h04, 6'h00);
        {flt_denormal_i, flt_divzero_i, res_special_i} = 3'h1;
        res_special_val_i = 32'h7fc00000;
        op(6'h3f, 1'b0, 12'h000, ONE, 32'h7fc00000, 6'h00, 6'h00);
        res_special_i = 1'b0;
        $display("corner cases done");
        clr = 1'b0;
        repeat (80) begin
            v = xs();
            w = xs();
            rnd_mode_i = v[1:0];
            res_sticky_i = v[9] & ~v[10];
            e = {{5{v[8]}}, v[8:2]};
            sg = {1'b1, w, v[31:9]};
            if (v[10]) sg[31:0] = 32'h0;
            x = rnd(w[5], e, sg, res_sticky_i, v[1:0]);
            op({w[3], 5'h1f}, w[5], e, sg, x[31:0], {x[32], 5'h00},
                {x[32] & ~w[3], 5'h00});
        end
        $display("random results done");
        report_and_stop();
    end
endmodule
